// ---- hdl/usbpw_pkg.sv ----
package usbpw_pkg;

  localparam int unsigned USBPW_ADDR_W = 4;
  localparam int unsigned USBPW_DATA_W = 32;
  localparam int unsigned USBPW_NUM_IRQ = 5;

  // register byte offsets
  localparam logic [3:0] USBPW_OFF_PORT_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] USBPW_OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] USBPW_OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] USBPW_OFF_CAPABILITY = 4'hc;

  // port_status_control field positions
  localparam int unsigned USBPW_BIT_PHY_LP = 23;
  localparam int unsigned USBPW_BIT_WAKE_ON_OVERCURRENT_EN = 22;
  localparam int unsigned USBPW_BIT_WAKE_ON_DISCONNECT_EN = 21;
  localparam int unsigned USBPW_BIT_WKCN = 20;
  localparam int unsigned USBPW_PTC_LSB = 16;
  localparam int unsigned USBPW_PTC_W = 4;
  localparam int unsigned USBPW_BIT_PORT_OWNER = 13;
  localparam int unsigned USBPW_BIT_PP = 12;

  // capability register
  localparam int unsigned USBPW_BIT_PPC = 0;

  // interrupt status and mask layout
  localparam int unsigned USBPW_IRQ_WAKE = 0;
  localparam int unsigned USBPW_IRQ_CONNECT = 1;
  localparam int unsigned USBPW_IRQ_DISCONNECT = 2;
  localparam int unsigned USBPW_IRQ_OVERCURRENT = 3;
  localparam int unsigned USBPW_IRQ_PHY_RESUME = 4;

  // reset values
  localparam logic USBPW_RST_PHY_LP = 1'b0;
  localparam logic USBPW_RST_WAKE_EN = 1'b0;
  localparam logic [3:0] USBPW_RST_PTC = 4'h0;
  localparam logic USBPW_RST_PP = 1'b0;
  localparam logic [4:0] USBPW_RST_IRQ_MASK = 5'h00;

  // test selector codes
  localparam logic [3:0] USBPW_PTC_NORMAL = 4'h0;
  localparam logic [3:0] USBPW_PTC_J_STATE = 4'h1;
  localparam logic [3:0] USBPW_PTC_K_STATE = 4'h2;
  localparam logic [3:0] USBPW_PTC_SEQ_NAK = 4'h3;
  localparam logic [3:0] USBPW_PTC_PACKET = 4'h4;
  localparam logic [3:0] USBPW_PTC_FORCE_EN = 4'h5;

endpackage : usbpw_pkg

// ---- hdl/usbpw_evt_if.sv ----
`timescale 1ns/10ps
interface usbpw_evt_if;
  logic wake_on_overcurrent_en_en;
  logic wake_on_disconnect_en_en;
  logic wkcn_en;
  logic pp;
  logic overcurrent;
  logic connect;
  logic disconnect;
  logic wake;
  logic connect_evt;
  logic disconnect_evt;
  logic overcurrent_evt;

  modport ctrl (
    output wake_on_overcurrent_en_en, wake_on_disconnect_en_en, wkcn_en, pp, overcurrent, connect, disconnect,
    input wake, connect_evt, disconnect_evt, overcurrent_evt
  );
  modport wake_side (
    input wake_on_overcurrent_en_en, wake_on_disconnect_en_en, wkcn_en, pp, overcurrent, connect, disconnect,
    output wake, connect_evt, disconnect_evt, overcurrent_evt
  );
endinterface : usbpw_evt_if

// ---- hdl/usbpw_phy_lp.sv ----
`timescale 1ns/10ps
module usbpw_phy_lp
  import usbpw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_mode,
  input wire logic wr_en,
  input wire logic wr_val,
  input wire logic resume_det,
  input wire logic force_resume,
  output logic lp_req,
  output logic auto_clr
);
  typedef struct packed {
    logic req;
    logic clr;
  } usbpw_lp_s;

  usbpw_lp_s st_r;
  usbpw_lp_s st_nxt;
  logic wake_bus;

  assign wake_bus = resume_det | force_resume;

  always_comb begin
    st_nxt = st_r;
    st_nxt.clr = 1'b0;
    // only software raises the request, in either mode
    if (wr_en) begin
      st_nxt.req = wr_val;
    end
    // in device mode only, bus resume beats a same-cycle write, the phy must wake
    if (!host_mode && wake_bus && (st_r.req || (wr_en && wr_val))) begin
      st_nxt.req = 1'b0;
      st_nxt.clr = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{req: USBPW_RST_PHY_LP, clr: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lp_req = st_r.req;
  assign auto_clr = st_r.clr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_LP_HOST_SW_ONLY: assert property (
    host_mode && !wr_en |=> $stable(lp_req))
    else $error("phy suspend request changed without a write in host mode");
  AST_LP_DEV_AUTO_CLR: assert property (
    !host_mode && wake_bus && lp_req |=> !lp_req && auto_clr)
    else $error("phy suspend not cleared on resume in device mode");
  COV_LP_AUTO_CLR: cover property (lp_req ##1 auto_clr);
endmodule : usbpw_phy_lp

// ---- hdl/usbpw_wake.sv ----
`timescale 1ns/10ps
module usbpw_wake
  import usbpw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  usbpw_evt_if.wake_side evt
);
  typedef struct packed {
    logic wake;
    logic conn;
    logic disc;
    logic oc;
  } usbpw_wake_s;

  usbpw_wake_s st_r;
  usbpw_wake_s st_nxt;

  always_comb begin
    // an unpowered port is dead: no attach, detach or other change
    st_nxt.conn = evt.pp & evt.connect;
    st_nxt.disc = evt.pp & evt.disconnect;
    st_nxt.oc = evt.pp & evt.overcurrent;
    st_nxt.wake = (evt.wake_on_overcurrent_en_en & st_nxt.oc)
      | (evt.wake_on_disconnect_en_en & st_nxt.disc)
      | (evt.wkcn_en & st_nxt.conn);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.wake = st_r.wake;
  assign evt.connect_evt = st_r.conn;
  assign evt.disconnect_evt = st_r.disc;
  assign evt.overcurrent_evt = st_r.oc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_NO_EVT_UNPOWERED: assert property (
    !evt.pp |=> !evt.connect_evt && !evt.disconnect_evt && !evt.wake)
    else $error("port change reported while port power is off");
  AST_WAKE_ON_OC: assert property (
    evt.pp && evt.wake_on_overcurrent_en_en && evt.overcurrent |=> evt.wake)
    else $error("enabled over-current did not raise wake");
  COV_WAKE_CONNECT: cover property (evt.wkcn_en && evt.connect ##1 evt.wake);
endmodule : usbpw_wake

// ---- hdl/usbpw_top.sv ----
`timescale 1ns/10ps
module usbpw_top
  import usbpw_pkg::*;
#(
  parameter bit DEVICE_ONLY = 1'b0
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [USBPW_ADDR_W-1:0] REG_ADDR,
  input wire logic [USBPW_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [USBPW_DATA_W-1:0] REG_RDATA,
  input wire logic HOST_MODE,
  input wire logic PHY_LP_STATUS,
  input wire logic RESUME_DET,
  input wire logic FORCE_RESUME,
  input wire logic OVERCURRENT,
  input wire logic CONNECT,
  input wire logic DISCONNECT,
  output logic PHY_SUSPEND,
  output logic [USBPW_PTC_W-1:0] TEST_SEL,
  output logic TEST_MODE,
  output logic PORT_POWER,
  output logic WAKE,
  output logic IRQ
);
  typedef struct packed {
    logic [USBPW_PTC_W-1:0] port_test_select;
    logic pp;
    logic wake_on_overcurrent_en;
    logic wake_on_disconnect_en;
    logic wkcn;
    logic test;
    logic [USBPW_NUM_IRQ-1:0] ists;
    logic [USBPW_NUM_IRQ-1:0] imask;
    logic [USBPW_DATA_W-1:0] rdata;
    logic irq;
  } usbpw_regs_s;

  localparam usbpw_regs_s USBPW_REGS_RST = '{
    port_test_select: USBPW_RST_PTC,
    pp: USBPW_RST_PP,
    wake_on_overcurrent_en: USBPW_RST_WAKE_EN,
    wake_on_disconnect_en: USBPW_RST_WAKE_EN,
    wkcn: USBPW_RST_WAKE_EN,
    test: 1'b0,
    ists: '0,
    imask: USBPW_RST_IRQ_MASK,
    rdata: '0,
    irq: 1'b0
  };

  function automatic logic usbpw_hit(
    input logic strobe,
    input logic [USBPW_ADDR_W-1:0] addr,
    input logic [USBPW_ADDR_W-1:0] off
  );
    usbpw_hit = strobe && (addr == off);
  endfunction : usbpw_hit

  usbpw_regs_s st_r;
  usbpw_regs_s st_nxt;
  usbpw_evt_if evt ();
  logic wr_psc;
  logic wr_mask;
  logic rd_psc;
  logic rd_ists;
  logic rd_mask;
  logic rd_cap;
  logic lp_req;
  logic lp_auto_clr;
  logic port_power_capability;
  logic [USBPW_NUM_IRQ-1:0] irq_set;

  assign wr_psc = usbpw_hit(REG_WR, REG_ADDR, USBPW_OFF_PORT_STATUS_CONTROL);
  assign wr_mask = usbpw_hit(REG_WR, REG_ADDR, USBPW_OFF_IRQ_MASK);
  assign rd_psc = usbpw_hit(REG_RD, REG_ADDR, USBPW_OFF_PORT_STATUS_CONTROL);
  assign rd_ists = usbpw_hit(REG_RD, REG_ADDR, USBPW_OFF_IRQ_STATUS);
  assign rd_mask = usbpw_hit(REG_RD, REG_ADDR, USBPW_OFF_IRQ_MASK);
  assign rd_cap = usbpw_hit(REG_RD, REG_ADDR, USBPW_OFF_CAPABILITY);

  // a device-only build has no power switch to steer
  assign port_power_capability = ~DEVICE_ONLY;

  usbpw_phy_lp u_phy_lp (
    .clk(CLK),
    .arst_n(ARST_N),
    .host_mode(HOST_MODE),
    .wr_en(wr_psc),
    .wr_val(REG_WDATA[USBPW_BIT_PHY_LP]),
    .resume_det(RESUME_DET),
    .force_resume(FORCE_RESUME),
    .lp_req(lp_req),
    .auto_clr(lp_auto_clr)
  );

  assign evt.wake_on_overcurrent_en_en = st_r.wake_on_overcurrent_en;
  assign evt.wake_on_disconnect_en_en = st_r.wake_on_disconnect_en;
  assign evt.wkcn_en = st_r.wkcn;
  assign evt.pp = st_r.pp;
  assign evt.overcurrent = OVERCURRENT;
  assign evt.connect = CONNECT;
  assign evt.disconnect = DISCONNECT;

  usbpw_wake u_wake (
    .clk(CLK),
    .arst_n(ARST_N),
    .evt(evt.ctrl)
  );

  always_comb begin
    irq_set = '0;
    irq_set[USBPW_IRQ_WAKE] = evt.wake;
    irq_set[USBPW_IRQ_CONNECT] = evt.connect_evt;
    irq_set[USBPW_IRQ_DISCONNECT] = evt.disconnect_evt;
    irq_set[USBPW_IRQ_OVERCURRENT] = evt.overcurrent_evt;
    irq_set[USBPW_IRQ_PHY_RESUME] = lp_auto_clr;
  end

  always_comb begin
    st_nxt = st_r;
    if (wr_psc) begin
      st_nxt.port_test_select = REG_WDATA[USBPW_PTC_LSB +: USBPW_PTC_W];
      st_nxt.pp = REG_WDATA[USBPW_BIT_PP];
      st_nxt.wake_on_overcurrent_en = REG_WDATA[USBPW_BIT_WAKE_ON_OVERCURRENT_EN];
      st_nxt.wake_on_disconnect_en = REG_WDATA[USBPW_BIT_WAKE_ON_DISCONNECT_EN];
      st_nxt.wkcn = REG_WDATA[USBPW_BIT_WKCN];
    end
    // no switch in a device-only build, power stays off
    if (!port_power_capability) begin
      st_nxt.pp = 1'b0;
    end
    // enables are held at zero rather than masked on read, so the wake
    // logic never sees a stale enable after power returns
    if (!st_nxt.pp) begin
      st_nxt.wake_on_overcurrent_en = 1'b0;
      st_nxt.wake_on_disconnect_en = 1'b0;
      st_nxt.wkcn = 1'b0;
    end
    if (!HOST_MODE) begin
      st_nxt.wake_on_disconnect_en = 1'b0;
      st_nxt.wkcn = 1'b0;
    end
    st_nxt.test = (st_nxt.port_test_select != USBPW_PTC_NORMAL);
    if (wr_mask) begin
      st_nxt.imask = REG_WDATA[USBPW_NUM_IRQ-1:0];
    end
    // read clears, but an event in the same cycle survives
    st_nxt.ists = (st_r.ists & ~{USBPW_NUM_IRQ{rd_ists}}) | irq_set;
    st_nxt.irq = |(st_nxt.ists & st_nxt.imask);
    st_nxt.rdata = '0;
    if (rd_psc) begin
      // phy status comes from the phy itself, not the request
      st_nxt.rdata[USBPW_BIT_PHY_LP] = PHY_LP_STATUS;
      st_nxt.rdata[USBPW_BIT_WAKE_ON_OVERCURRENT_EN] = st_r.wake_on_overcurrent_en;
      // a mode change reaches the stored enables a cycle late, so mask here
      st_nxt.rdata[USBPW_BIT_WAKE_ON_DISCONNECT_EN] = st_r.wake_on_disconnect_en & HOST_MODE;
      st_nxt.rdata[USBPW_BIT_WKCN] = st_r.wkcn & HOST_MODE;
      st_nxt.rdata[USBPW_PTC_LSB +: USBPW_PTC_W] = st_r.port_test_select;
      st_nxt.rdata[USBPW_BIT_PORT_OWNER] = 1'b0;
      st_nxt.rdata[USBPW_BIT_PP] = st_r.pp;
      // bits 15:14 left at zero
    end else if (rd_ists) begin
      st_nxt.rdata[USBPW_NUM_IRQ-1:0] = st_r.ists;
    end else if (rd_mask) begin
      st_nxt.rdata[USBPW_NUM_IRQ-1:0] = st_r.imask;
    end else if (rd_cap) begin
      st_nxt.rdata[USBPW_BIT_PPC] = port_power_capability;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= USBPW_REGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign PHY_SUSPEND = lp_req;
  assign TEST_SEL = st_r.port_test_select;
  assign TEST_MODE = st_r.test;
  assign PORT_POWER = st_r.pp;
  assign WAKE = evt.wake;
  assign IRQ = st_r.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_LP_READ_STATUS: assert property (
    rd_psc |=> REG_RDATA[USBPW_BIT_PHY_LP] == $past(PHY_LP_STATUS))
    else $error("phy suspend read does not show phy status");
  AST_LP_WRITE: assert property (
    wr_psc && !RESUME_DET && !FORCE_RESUME
    |=> PHY_SUSPEND == $past(REG_WDATA[USBPW_BIT_PHY_LP]))
    else $error("phy suspend request does not follow the write");
  AST_WAKE_ON_OVERCURRENT_EN_UNPOWERED: assert property (
    !PORT_POWER |-> !st_r.wake_on_overcurrent_en)
    else $error("over-current wake enable set while unpowered");
  AST_WAKE_ON_DISCONNECT_EN_DEVICE: assert property (
    rd_psc && !HOST_MODE ##1 !HOST_MODE |-> !REG_RDATA[USBPW_BIT_WAKE_ON_DISCONNECT_EN])
    else $error("disconnect wake enable read one in device mode");
  AST_WKCN_UNPOWERED: assert property (
    rd_psc && !PORT_POWER |=> !REG_RDATA[USBPW_BIT_WKCN])
    else $error("connect wake enable read one while unpowered");
  AST_TEST_MODE: assert property (
    TEST_MODE == (TEST_SEL != USBPW_PTC_NORMAL))
    else $error("test mode flag disagrees with selector");
  AST_PORT_OWNER_ZERO: assert property (
    rd_psc |=> !REG_RDATA[USBPW_BIT_PORT_OWNER])
    else $error("port owner read as one");
  AST_PP_READ: assert property (
    rd_psc |=> REG_RDATA[USBPW_BIT_PP] == $past(PORT_POWER))
    else $error("port power read differs from switch state");
  AST_DEVICE_ONLY_PP: assert property (
    !port_power_capability |-> !PORT_POWER)
    else $error("port power on in a device-only build");
  AST_RSVD_ZERO: assert property (
    rd_psc |=> REG_RDATA[15:14] == 2'h0)
    else $error("reserved bits read nonzero");
  AST_IRQ_LEVEL: assert property (
    IRQ == |(st_r.ists & st_r.imask))
    else $error("interrupt output disagrees with status and mask");

  // read data stand for the one cycle after a read only
  AST_RDATA_IDLE: assert property (
    !REG_RD |=> REG_RDATA == '0)
    else $error("read data nonzero without a read");

  AST_WAKE_ON_OVERCURRENT_EN_READ_UNPOWERED: assert property (
    rd_psc && !PORT_POWER |=> !REG_RDATA[USBPW_BIT_WAKE_ON_OVERCURRENT_EN])
    else $error("over-current wake enable read one while unpowered");

  AST_WAKE_ON_DISCONNECT_EN_UNPOWERED: assert property (
    rd_psc && !PORT_POWER |=> !REG_RDATA[USBPW_BIT_WAKE_ON_DISCONNECT_EN])
    else $error("disconnect wake enable read one while unpowered");

  AST_WKCN_DEVICE: assert property (
    rd_psc && !HOST_MODE |=> !REG_RDATA[USBPW_BIT_WKCN])
    else $error("connect wake enable read one in device mode");

  AST_TEST_SEL_WRITE: assert property (
    wr_psc
    |=> TEST_SEL == $past(REG_WDATA[USBPW_PTC_LSB +: USBPW_PTC_W]))
    else $error("test selector does not follow the write");

  AST_PP_WRITE: assert property (
    wr_psc && port_power_capability |=> PORT_POWER == $past(REG_WDATA[USBPW_BIT_PP]))
    else $error("port power does not follow the write");

  AST_PP_HOLD: assert property (
    !wr_psc |=> $stable(PORT_POWER))
    else $error("port power changed without a write");

  AST_CAP_READ: assert property (
    rd_cap |=> REG_RDATA[USBPW_BIT_PPC] == port_power_capability)
    else $error("power capability read wrong for this build");

  // each reported event lands in its sticky bit one cycle later
  AST_WAKE_STATUS: assert property (
    WAKE |=> st_r.ists[USBPW_IRQ_WAKE])
    else $error("wake did not set its status bit");

  AST_CONNECT_STATUS: assert property (
    evt.connect_evt |=> st_r.ists[USBPW_IRQ_CONNECT])
    else $error("connect did not set its status bit");

  AST_OC_STATUS: assert property (
    evt.overcurrent_evt |=> st_r.ists[USBPW_IRQ_OVERCURRENT])
    else $error("over-current did not set its status bit");

  AST_RESUME_STATUS: assert property (
    lp_auto_clr |=> st_r.ists[USBPW_IRQ_PHY_RESUME])
    else $error("phy auto-resume did not set its status bit");

  AST_STATUS_READ_CLEAR: assert property (
    rd_ists && irq_set == '0 |=> st_r.ists == '0)
    else $error("status read did not clear the sticky bits");

  AST_NO_CHANGE_UNPOWERED: assert property (
    !PORT_POWER
    |=> !evt.connect_evt && !evt.disconnect_evt && !evt.overcurrent_evt)
    else $error("port event reported while port power is off");

  COV_TEST_PACKET: cover property (TEST_SEL == USBPW_PTC_PACKET);
  COV_IRQ_READ_CLEAR: cover property (IRQ && rd_ists ##1 !IRQ);
  COV_POWER_UP_WAKE: cover property (wr_psc ##1 PORT_POWER ##[1:4] WAKE);
endmodule : usbpw_top

// ---- testbench/usbpw_phy_model.sv ----
`timescale 1ns/10ps
module usbpw_phy_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic phy_suspend,
  output logic phy_lp_status
);
  // LAT of 2 or more; the phy settles into or out of low power slowly
  // the phy clock never stops here, so suspend may be cleared
  logic [LAT-1:0] dly_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[LAT-2:0], phy_suspend};
    end
  end

  assign phy_lp_status = dly_r[LAT-1];
endmodule : usbpw_phy_model

// ---- testbench/usb_port_power_wake_test_ctrl_test.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module usb_port_power_wake_test_ctrl_test;
  import usbpw_pkg::*;
  localparam logic [31:0] LP = 32'h1 << USBPW_BIT_PHY_LP;
  localparam logic [31:0] OC = 32'h1 << USBPW_BIT_WAKE_ON_OVERCURRENT_EN;
  localparam logic [31:0] DS = 32'h1 << USBPW_BIT_WAKE_ON_DISCONNECT_EN;
  localparam logic [31:0] CN = 32'h1 << USBPW_BIT_WKCN;
  localparam logic [31:0] PP = 32'h1 << USBPW_BIT_PP;
  localparam logic [31:0] EN = OC | DS | CN;
  localparam logic [3:0] PSC = USBPW_OFF_PORT_STATUS_CONTROL;
  localparam logic [3:0] STA = USBPW_OFF_IRQ_STATUS;
  logic clk, arst_n, wr, rd, host, lp_stat, suspend, mode, pwr, wake, irq;
  logic [3:0] addr, tsel;
  logic [31:0] wdata, rdata, rdata_dev, rdv, rdv_dev;
  logic [2:0] ev;
  logic [1:0] rs;
  logic [4:0] mask;
  int fails, checked;

  usbpw_top #(.DEVICE_ONLY(1'b0)) u_dut (
    .CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .HOST_MODE(host),
    .PHY_LP_STATUS(lp_stat), .RESUME_DET(rs[0]), .FORCE_RESUME(rs[1]),
    .OVERCURRENT(ev[2]), .CONNECT(ev[0]), .DISCONNECT(ev[1]),
    .PHY_SUSPEND(suspend), .TEST_SEL(tsel), .TEST_MODE(mode),
    .PORT_POWER(pwr), .WAKE(wake), .IRQ(irq)
  );

  usbpw_top #(.DEVICE_ONLY(1'b1)) u_dut_dev (
    .CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata_dev), .HOST_MODE(host),
    .PHY_LP_STATUS(lp_stat), .RESUME_DET(rs[0]), .FORCE_RESUME(rs[1]),
    .OVERCURRENT(ev[2]), .CONNECT(ev[0]), .DISCONNECT(ev[1]),
    .PHY_SUSPEND(), .TEST_SEL(), .TEST_MODE(), .PORT_POWER(), .WAKE(),
    .IRQ()
  );

  usbpw_phy_model #(.LAT(3)) u_phy (
    .clk(clk), .arst_n(arst_n), .phy_suspend(suspend), .phy_lp_status(lp_stat)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rdv = rdata;
    rdv_dev = rdata_dev;
  endtask : rd_reg

  task automatic evt(input logic [2:0] v, input logic ew,
                     input logic [31:0] es);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 3'h0;
    #1;
    `CHK(wake, ew)
    @(posedge clk);
    #1;
    `CHK(irq, |(es[4:0] & mask))
    rd_reg(STA);
    `CHK(rdv, es)
    // a second read proves the first one cleared the sticky bits
    rd_reg(STA);
    `CHK(rdv, 32'h0)
    `CHK(irq, 1'b0)
  endtask : evt

  task automatic rpulse(input logic [1:0] v);
    @(posedge clk);
    rs <= v;
    @(posedge clk);
    rs <= 2'h0;
    #1;
  endtask : rpulse

  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    checked = 0;
    arst_n = 1'b0;
    {wr, rd, addr, wdata, ev, rs, mask} = '0;
    host = 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(PSC);
    `CHK(rdv, 32'h0)
    rd_reg(USBPW_OFF_CAPABILITY);
    `CHK(rdv, 32'h1 << USBPW_BIT_PPC)
    `CHK(rdv_dev, 32'h0)
    rd_reg(4'h1);
    `CHK(rdv, 32'h0)
    wr_reg(PSC, EN);
    rd_reg(PSC);
    `CHK(rdv, 32'h0)
    wr_reg(PSC, EN | PP | 32'h0000_e000);
    `CHK(pwr, 1'b1)
    rd_reg(PSC);
    `CHK(rdv, EN | PP)
    `CHK(rdv_dev, 32'h0)
    for (int i = 0; i < 16; i++) begin
      wr_reg(PSC, EN | PP | (32'(i) << USBPW_PTC_LSB));
      `CHK(tsel, 4'(i))
      `CHK(mode, 1'(i != 0))
    end
    mask = 5'h1f;
    wr_reg(USBPW_OFF_IRQ_MASK, 32'h1f);
    for (int k = 0; k < 3; k++) begin
      evt(3'(1 << k), 1'b1, 32'h1 | (32'h2 << k));
    end
    // software drops power after the over-current, then restores it
    wr_reg(PSC, EN);
    `CHK(pwr, 1'b0)
    wr_reg(PSC, EN | PP);
    mask = 5'h0;
    wr_reg(USBPW_OFF_IRQ_MASK, 32'h0);
    evt(3'h1, 1'b1, 32'h3);
    wr_reg(PSC, OC | PP);
    evt(3'h1, 1'b0, 32'h2);
    @(posedge clk);
    host <= 1'b0;
    wr_reg(PSC, EN | PP);
    rd_reg(PSC);
    `CHK(rdv, OC | PP)
    // the controller is held stopped, so device-mode suspend is allowed
    wr_reg(PSC, LP | PP);
    `CHK(suspend, 1'b1)
    rd_reg(PSC);
    `CHK(rdv, PP)
    repeat (4) @(posedge clk);
    rd_reg(PSC);
    `CHK(rdv, LP | PP)
    rpulse(2'h1);
    `CHK(suspend, 1'b0)
    rd_reg(STA);
    `CHK(rdv, 32'h1 << USBPW_IRQ_PHY_RESUME)
    wr_reg(PSC, LP | PP);
    rpulse(2'h2);
    `CHK(suspend, 1'b0)
    rd_reg(STA);
    `CHK(rdv, 32'h1 << USBPW_IRQ_PHY_RESUME)
    @(posedge clk);
    host <= 1'b1;
    wr_reg(PSC, LP | PP);
    rpulse(2'h3);
    `CHK(suspend, 1'b1)
    wr_reg(PSC, EN);
    `CHK(suspend, 1'b0)
    `CHK(pwr, 1'b0)
    rd_reg(PSC);
    `CHK(rdv[22:12], 11'h0)
    evt(3'h7, 1'b0, 32'h0);
    report_and_stop();
  end
endmodule : usb_port_power_wake_test_ctrl_test
